// file: src/pew_host.sv
// Host controller that drives a four-bank parallel EEPROM over its pins.
// Assumes the user issues one request at a time while ready is high; pins are asynchronous.
`timescale 1ns/10ps
module pew_host #(
  parameter int ADDR_W        = 17,
  parameter int PROGRAM_WAIT  = pew_pkg::PROGRAM_CYCLES,
  parameter int PROTECT_WAIT  = pew_pkg::PROTECT_CYCLES,
  parameter int LOAD_END_WAIT = pew_pkg::LOAD_END_CYCLES,
  parameter int WINDOW_WAIT   = pew_pkg::WINDOW_CYCLES,
  parameter bit USE_POLL      = 1'b1
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic              req_last,
  input  wire logic [1:0]        req_bank,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [7:0]        req_wdata,
  input  wire logic              protect_en,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_rdata,
  output logic                   prog_busy,
  output logic                   page_error,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [3:0]             bank_select_n,
  output logic                   oe_n,
  output logic                   we_n,
  output logic                   protect_hold_n,
  output logic [7:0]             data_out,
  output logic                   data_oe,
  input  wire logic [7:0]        data_in,
  input  wire logic              rdy_busy_in
);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  typedef enum logic [3:0] {
    PEW_PROTECT, PEW_IDLE, PEW_RD_STROBE,
    PEW_WR_STROBE, PEW_WR_GAP, PEW_PAGE_WAIT,
    PEW_START_WAIT, PEW_POLL_STROBE, PEW_PROGRAM
  } pew_state_t;

  // The shared counter must hold the longest wait, whichever parameter that is.
  localparam int CNT_W = $clog2(PROGRAM_WAIT + PROTECT_WAIT + LOAD_END_WAIT + WINDOW_WAIT
                                + pew_pkg::SPACING_CYCLES) + 1;
  localparam int BYTE_W = $clog2(pew_pkg::PAGE_BYTES + 1);
  pew_state_t        state_ff, nxt_state;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic [CNT_W-1:0]  gap_ff, nxt_gap;
  logic [BYTE_W-1:0] bytes_ff, nxt_bytes;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [3:0]        sel_n_ff, nxt_sel_n, sel_bank_ff, nxt_sel_bank;
  logic [7:0]        data_s1_ff, data_s2_ff;
  logic              rb_s1_ff, rb_s2_ff;
  logic              oe_n_ff, nxt_oe_n, we_n_ff, nxt_we_n;
  logic              hold_n_ff, nxt_hold_n;
  logic [7:0]        dout_ff, nxt_dout;
  logic              doe_ff, nxt_doe;
  logic              ready_ff, nxt_ready, rvalid_ff, nxt_rvalid;
  logic [7:0]        rdata_ff, nxt_rdata;
  logic              busy_ff, nxt_busy, perr_ff, nxt_perr, last_ff, nxt_last;

  function automatic logic [3:0] bank_decode(input logic [1:0] b);
    bank_decode = ~(4'h1 << b);
  endfunction
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_gap    = (gap_ff != '0) ? gap_ff - cyc(1) : gap_ff;
    nxt_bytes  = bytes_ff;
    nxt_addr   = addr_ff;
    nxt_sel_n  = sel_n_ff;
    nxt_sel_bank = sel_bank_ff;
    nxt_oe_n   = oe_n_ff;
    nxt_we_n   = we_n_ff;
    nxt_hold_n = hold_n_ff;
    nxt_dout   = dout_ff;
    nxt_doe    = doe_ff;
    nxt_ready  = 1'b0;
    nxt_rvalid = 1'b0;
    nxt_rdata  = rdata_ff;
    nxt_busy   = busy_ff;
    nxt_perr   = perr_ff;
    nxt_last   = last_ff;
    case (state_ff)
      PEW_PROTECT: begin
        nxt_hold_n = ~protect_en;
        if (protect_en || cnt_ff == '0) begin
          nxt_cnt = cyc(PROTECT_WAIT);
        end else if (cnt_ff == cyc(1)) begin
          nxt_state = PEW_IDLE;
          nxt_ready = 1'b1;
          nxt_cnt   = '0;
        end else begin
          nxt_cnt = cnt_ff - cyc(1);
        end
      end
      PEW_IDLE: begin
        nxt_ready = 1'b1;
        if (req_valid && ready_ff) begin
          nxt_ready = 1'b0;
          nxt_addr  = req_addr;
          nxt_sel_n = bank_decode(req_bank);
          if (req_write) begin
            nxt_state = PEW_WR_STROBE;
            nxt_we_n  = 1'b0;
            nxt_dout  = req_wdata;
            nxt_doe   = 1'b0;
            nxt_last  = req_last;
            nxt_cnt   = cyc(pew_pkg::STROBE_CYCLES);
          end else begin
            nxt_state = PEW_RD_STROBE;
            nxt_oe_n  = 1'b0;
            nxt_cnt   = cyc(pew_pkg::ACCESS_CYCLES);
          end
        end
      end
      PEW_RD_STROBE: begin
        nxt_cnt = cnt_ff - cyc(1);
        if (cnt_ff == cyc(1)) begin
          nxt_rdata  = data_s2_ff;
          nxt_rvalid = 1'b1;
          nxt_oe_n   = 1'b1;
          nxt_sel_n  = pew_pkg::BANKS_IDLE;
          nxt_state  = PEW_IDLE;
          nxt_ready  = 1'b1;
        end
      end
      PEW_WR_STROBE: begin
        nxt_cnt = cnt_ff - cyc(1);
        nxt_sel_bank = ~sel_n_ff;
        if (cnt_ff == cyc(1)) begin
          nxt_we_n  = 1'b1;
          nxt_doe   = 1'b1;
          nxt_sel_n = pew_pkg::BANKS_IDLE;
          nxt_bytes = bytes_ff + BYTE_W'(1);
          nxt_gap   = cyc(pew_pkg::SPACING_CYCLES);
          nxt_busy  = 1'b1;
          nxt_cnt   = cyc(WINDOW_WAIT);
          nxt_state = PEW_WR_GAP;
        end
      end
      PEW_WR_GAP: begin
        nxt_cnt = cnt_ff - cyc(1);
        if (last_ff || bytes_ff == BYTE_W'(pew_pkg::PAGE_BYTES)) begin
          nxt_state = PEW_PAGE_WAIT;
          nxt_cnt   = cyc(LOAD_END_WAIT);
        end else if (gap_ff <= cyc(1)) begin
          nxt_ready = 1'b1;
          if (req_valid && ready_ff && req_write) begin
            nxt_ready = 1'b0;
            nxt_addr  = req_addr;
            nxt_sel_n = bank_decode(req_bank);
            nxt_we_n  = 1'b0;
            nxt_dout  = req_wdata;
            nxt_doe   = 1'b0;
            nxt_last  = req_last;
            nxt_cnt   = cyc(pew_pkg::STROBE_CYCLES);
            nxt_state = PEW_WR_STROBE;
          end else if (cnt_ff == cyc(1)) begin
            nxt_ready = 1'b0;
            nxt_state = PEW_PAGE_WAIT;
            nxt_cnt   = cyc(LOAD_END_WAIT);
          end
        end
      end
      PEW_PAGE_WAIT: begin
        nxt_cnt = cnt_ff - cyc(1);
        if (req_valid && req_write && bytes_ff == BYTE_W'(pew_pkg::PAGE_BYTES)) begin
          nxt_perr = 1'b1;
        end
        if (cnt_ff == cyc(1)) begin
          nxt_state = PEW_START_WAIT;
          nxt_cnt   = cyc(pew_pkg::WSTART_CYCLES);
        end
      end
      PEW_START_WAIT: begin
        nxt_cnt = cnt_ff - cyc(1);
        if (cnt_ff == cyc(1)) begin
          nxt_state = PEW_PROGRAM;
          nxt_cnt   = cyc(PROGRAM_WAIT);
        end
      end
      PEW_PROGRAM: begin
        nxt_cnt = cnt_ff - cyc(1);
        if ((USE_POLL && rb_s2_ff) || cnt_ff == cyc(1)) begin
          nxt_state = PEW_POLL_STROBE;
          nxt_sel_n = ~sel_bank_ff;
          nxt_oe_n  = 1'b0;
          nxt_cnt   = cyc(pew_pkg::ACCESS_CYCLES);
        end
      end
      PEW_POLL_STROBE: begin
        nxt_cnt = cnt_ff - cyc(1);
        if (cnt_ff == cyc(1)) begin
          nxt_oe_n  = 1'b1;
          nxt_sel_n = pew_pkg::BANKS_IDLE;
          if (data_s2_ff[pew_pkg::TOP_BIT] == dout_ff[pew_pkg::TOP_BIT]) begin
            nxt_state = PEW_IDLE;
            nxt_busy  = 1'b0;
            nxt_bytes = '0;
            nxt_perr  = 1'b0;
            nxt_ready = 1'b1;
          end else begin
            nxt_state = PEW_PROGRAM;
            nxt_cnt   = cyc(PROGRAM_WAIT);
          end
        end
      end
      default: begin
        nxt_state = PEW_PROTECT;
      end
    endcase
    // Protect wins in every state: pins go quiet and a program in flight is abandoned.
    if (protect_en) begin
      nxt_state  = PEW_PROTECT;
      nxt_hold_n = 1'b0;
      nxt_cnt    = '0;
      nxt_sel_n  = pew_pkg::BANKS_IDLE;
      nxt_oe_n   = 1'b1;
      nxt_we_n   = 1'b1;
      nxt_doe    = 1'b1;
      nxt_ready  = 1'b0;
      nxt_busy   = 1'b0;
      nxt_bytes  = '0;
      nxt_perr   = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff  <= PEW_PROTECT;
      cnt_ff    <= '0;
      gap_ff    <= '0;
      bytes_ff  <= '0;
      addr_ff   <= '0;
      sel_n_ff  <= pew_pkg::BANKS_IDLE;
      oe_n_ff   <= 1'b1;
      we_n_ff   <= 1'b1;
      hold_n_ff <= 1'b0;
      dout_ff   <= 8'h00;
      doe_ff    <= 1'b1;
      ready_ff  <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 8'h00;
      busy_ff   <= 1'b0;
      perr_ff   <= 1'b0;
      last_ff   <= 1'b0;
      sel_bank_ff <= 4'h0;
      data_s1_ff  <= 8'h00;
      data_s2_ff  <= 8'h00;
      rb_s1_ff    <= 1'b1;
      rb_s2_ff    <= 1'b1;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      gap_ff    <= nxt_gap;
      bytes_ff  <= nxt_bytes;
      addr_ff   <= nxt_addr;
      sel_n_ff  <= nxt_sel_n;
      oe_n_ff   <= nxt_oe_n;
      we_n_ff   <= nxt_we_n;
      hold_n_ff <= nxt_hold_n;
      dout_ff   <= nxt_dout;
      doe_ff    <= nxt_doe;
      ready_ff  <= nxt_ready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      busy_ff   <= nxt_busy;
      perr_ff   <= nxt_perr;
      last_ff   <= nxt_last;
      sel_bank_ff <= nxt_sel_bank;
      data_s1_ff  <= data_in;
      data_s2_ff  <= data_s1_ff;
      rb_s1_ff    <= rdy_busy_in;
      rb_s2_ff    <= rb_s1_ff;
    end
  end

  assign req_ready      = ready_ff;
  assign rsp_valid      = rvalid_ff;
  assign rsp_rdata      = rdata_ff;
  assign prog_busy      = busy_ff;
  assign page_error     = perr_ff;
  assign mem_addr       = addr_ff;
  assign bank_select_n  = sel_n_ff;
  assign oe_n           = oe_n_ff;
  assign we_n           = we_n_ff;
  assign protect_hold_n = hold_n_ff;
  assign data_out       = dout_ff;
  assign data_oe        = doe_ff;

endmodule

// file: src/pew_pkg.sv
// Constants shared by the host-side controller of a four-bank parallel EEPROM module.
// Assumes one 40 MHz core clock; all pin timings are counted in its cycles.
// Behaviour
// - Without polling, wait beyond 15 ms.
// - With polling, next access after 150 ns.
// - Protect pin high 100 us before writes.
// - Byte loads in page at least 1 us apart.
// - At most one bank select asserted.
// - Page 1..128 bytes, 30 us gap, 100 us ends.
package pew_pkg;

  localparam int CLK_MHZ         = 40;
  localparam int CYCLE_LIMIT_MS  = 15;
  localparam int WRITE_START_NS  = 150;
  localparam int PROTECT_SETUP_US = 100;
  localparam int LOAD_SPACING_US = 1;
  localparam int LOAD_WINDOW_US  = 30;
  localparam int LOAD_END_US     = 100;
  localparam int PAGE_BYTES      = 128;
  localparam int STROBE_NS       = 250;
  localparam int ACCESS_NS       = 250;

  // Least times round up, longest times round down.
  localparam int PROGRAM_CYCLES  = CYCLE_LIMIT_MS * 1000 * CLK_MHZ + 1;
  localparam int WSTART_CYCLES   = (WRITE_START_NS * CLK_MHZ + 999) / 1000;
  localparam int PROTECT_CYCLES  = PROTECT_SETUP_US * CLK_MHZ;
  localparam int SPACING_CYCLES  = LOAD_SPACING_US * CLK_MHZ;
  localparam int WINDOW_CYCLES   = LOAD_WINDOW_US * CLK_MHZ;
  localparam int LOAD_END_CYCLES = LOAD_END_US * CLK_MHZ + 1;
  localparam int STROBE_CYCLES   = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACCESS_CYCLES   = (ACCESS_NS * CLK_MHZ + 999) / 1000 + 1;

  localparam logic [3:0] BANKS_IDLE = 4'hF;

  localparam int TOP_BIT = 7;

  typedef enum logic [1:0] {
    PEW_OP_READ,
    PEW_OP_WRITE,
    PEW_OP_PAGE_END,
    PEW_OP_NONE
  } pew_op_t;

endpackage

// file: test/parallel_eeprom_write_control_test.sv
// Self-checking bench for the host controller of a four-bank parallel EEPROM.
// Assumes the device model and the checker file are compiled before it.
`timescale 1ns/10ps
module parallel_eeprom_write_control_test;
  typedef struct packed {logic wr; logic [1:0] bank; logic [16:0] addr; logic [7:0] data;} pew_row_t;
  localparam int PROTECT_WAIT = 20;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0, req_write = 1'b0, req_last = 1'b0, protect_en = 1'b0;
  logic [1:0]  req_bank = 2'h0;
  logic [16:0] req_addr = 17'h0_0000, mem_addr;
  logic [7:0]  req_wdata = 8'h00, rsp_rdata, data_out, data_in;
  logic        req_ready, rsp_valid, prog_busy, page_error, oe_n, we_n, protect_hold_n, data_oe, rdy_busy_in;
  logic [3:0]  bank_select_n;
  int          num_errors = 0, comparisons = 0, cycles = 0;
  pew_row_t    rows [8] = '{'{1'b0, 2'h2, 17'h0_0010, 8'hFF}, '{1'b1, 2'h0, 17'h0_0000, 8'h5A},
                            '{1'b0, 2'h0, 17'h0_0000, 8'h5A}, '{1'b1, 2'h3, 17'h1_FFFF, 8'hA5},
                            '{1'b0, 2'h3, 17'h1_FFFF, 8'hA5}, '{1'b1, 2'h1, 17'h0_0123, 8'h80},
                            '{1'b0, 2'h1, 17'h0_0123, 8'h80}, '{1'b0, 2'h2, 17'h0_0123, 8'hFF}};

  pew_host #(.PROGRAM_WAIT(50), .PROTECT_WAIT(PROTECT_WAIT), .LOAD_END_WAIT(61)) u_pew_host (.core_clk, .rst_n,
    .req_valid, .req_write, .req_last, .req_bank, .req_addr, .req_wdata, .protect_en, .req_ready, .rsp_valid,
    .rsp_rdata, .prog_busy, .page_error, .mem_addr, .bank_select_n, .oe_n, .we_n, .protect_hold_n, .data_out,
    .data_oe, .data_in, .rdy_busy_in);
  pew_dev_model u_pew_dev_model (.core_clk, .mem_addr, .bank_select_n, .oe_n, .we_n, .protect_hold_n,
    .data_out, .data_in, .rdy_busy_in);

  always #12.5 core_clk = ~core_clk;

  // ********************
  // Shared tasks
  // ********************
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Issues one request at a falling edge; a read waits for its answer and compares it.
  task automatic send(input pew_row_t r, input logic last);
    for (int n = 0; n < 3000 && req_ready !== 1'b1; n++) @(negedge core_clk);
    req_valid = 1'b1;
    req_write = r.wr;
    req_last = last;
    req_bank = r.bank;
    req_addr = r.addr;
    req_wdata = r.data;
    @(negedge core_clk);
    req_valid = 1'b0;
    if (!r.wr) begin
      for (int n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(negedge core_clk);
      check(rsp_rdata, r.data);
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      finish_test();
    end
  end

  // ********************
  // Scenarios
  // ********************
  initial begin
    repeat (20) @(negedge core_clk);
    check(req_ready, 1'b0);
    check(protect_hold_n, 1'b0);
    check(bank_select_n, 4'hF);
    check(data_oe, 1'b1);
    rst_n = 1'b1;
    foreach (rows[i]) send(rows[i], 1'b1);
    send('{1'b1, 2'h2, 17'h0_0040, 8'h11}, 1'b0);
    send('{1'b1, 2'h2, 17'h0_0041, 8'hEE}, 1'b1);
    send('{1'b0, 2'h2, 17'h0_0040, 8'h11}, 1'b1);
    send('{1'b0, 2'h2, 17'h0_0041, 8'hEE}, 1'b1);
    send('{1'b1, 2'h1, 17'h0_0007, 8'h3C}, 1'b1);
    repeat (40) @(negedge core_clk);
    protect_en = 1'b1;
    repeat (3) @(negedge core_clk);
    check(protect_hold_n, 1'b0);
    check(rdy_busy_in, 1'b1);
    protect_en = 1'b0;
    send('{1'b0, 2'h1, 17'h0_0007, 8'hFF}, 1'b1);
    for (int i = 0; i < 128; i++) send('{1'b1, 2'h0, 17'(i), 8'(i)}, 1'b0);
    req_valid = 1'b1;
    for (int n = 0; n < 200 && page_error !== 1'b1; n++) @(negedge core_clk);
    req_valid = 1'b0;
    check(page_error, 1'b1);
    check(prog_busy, 1'b1);
    send('{1'b0, 2'h0, 17'h0_007F, 8'h7F}, 1'b1);
    check(page_error, 1'b0);
    check(prog_busy, 1'b0);
    finish_test();
  end
endmodule

bind pew_host pew_host_properties #(.PROTECT_WAIT(PROTECT_WAIT)) u_pew_host_properties (.core_clk, .rst_n,
  .req_valid, .req_write, .req_ready, .rsp_valid, .page_error, .bank_select_n, .oe_n, .we_n, .protect_hold_n,
  .data_oe);

// file: test/pew_dev_model.sv
// Behavioural four-bank parallel EEPROM with page load and self-timed program.
// Assumes host pins change on core_clk edges; ready/busy has a pull-up.
`timescale 1ns/10ps
module pew_dev_model #(
  parameter int END_T  = 60,
  parameter int PROG_T = 30
) (
  input wire logic        core_clk,
  input wire logic [16:0] mem_addr,
  input wire logic [3:0]  bank_select_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        protect_hold_n,
  input wire logic [7:0]  data_out,
  output logic [7:0]      data_in,
  output logic            rdy_busy_in
);
  logic [7:0]  mem [logic [18:0]];
  logic [18:0] pg_a [$];
  logic [7:0]  pg_d [$];
  logic [18:0] cur_a;
  logic [7:0]  cur_d;
  logic [7:0]  last_d = 8'h00;
  logic [7:0]  hold_d = 8'h00;
  logic [7:0]  rd_d;
  logic        busy = 1'b0;
  logic        we_q = 1'b1;
  int          idle;
  int          prog = 0;
  wire  [1:0]  bank = !bank_select_n[1] ? 2'h1 : !bank_select_n[2] ? 2'h2 : !bank_select_n[3] ? 2'h3 : 2'h0;
  wire         rd = !(&bank_select_n) && !oe_n && we_n && protect_hold_n;

  always @* rd_d = busy ? ~last_d : (mem.exists({bank, mem_addr}) ? mem[{bank, mem_addr}] : 8'hFF);
  // A released bus shows the inverse of its last value, never a held copy.
  assign data_in = rd ? rd_d : ~hold_d;
  assign rdy_busy_in = !busy;

  always @(posedge core_clk) begin
    we_q <= we_n;
    if (rd) hold_d <= rd_d;
    if (!protect_hold_n) begin
      pg_a.delete();
      pg_d.delete();
      prog = 0;
      busy <= 1'b0;
    end else if (!we_n && !(&bank_select_n)) begin
      cur_a = {bank, mem_addr};
      cur_d = data_out;
      idle = 0;
      busy <= 1'b1;
    end else if (we_n && !we_q) begin
      pg_a.push_back(cur_a);
      pg_d.push_back(cur_d);
      last_d = cur_d;
    end else if (pg_a.size() > 0 && prog == 0 && &bank_select_n && ++idle == END_T) begin
      prog = PROG_T;
    end else if (prog > 0 && --prog == 0) begin
      foreach (pg_a[i]) mem[pg_a[i]] = pg_d[i];
      pg_a.delete();
      pg_d.delete();
      busy <= 1'b0;
    end
  end
endmodule

// file: test/pew_host_properties.sv
// Checker for the host controller of a four-bank parallel EEPROM.
// Assumes it is bound to pew_host and sees only its ports.
`timescale 1ns/10ps
module pew_host_properties #(
  parameter int PROTECT_WAIT = 20
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       req_valid,
  input wire logic       req_write,
  input wire logic       req_ready,
  input wire logic       rsp_valid,
  input wire logic       page_error,
  input wire logic [3:0] bank_select_n,
  input wire logic       oe_n,
  input wire logic       we_n,
  input wire logic       protect_hold_n,
  input wire logic       data_oe
);
  // ********************
  // Cycle counters
  // ********************
  int   gap_ff;
  int   nxt_gap;
  int   hold_ff;
  int   nxt_hold;
  logic we_ff;

  always_comb begin
    nxt_gap  = (!we_n && we_ff) ? 0 : (gap_ff < 100 ? gap_ff + 1 : gap_ff);
    nxt_hold = !protect_hold_n ? 0 : (hold_ff < 99999 ? hold_ff + 1 : hold_ff);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_ff  <= 100;
      hold_ff <= 0;
      we_ff   <= 1'b1;
    end else begin
      gap_ff  <= nxt_gap;
      hold_ff <= nxt_hold;
      we_ff   <= we_n;
    end
  end

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_one_bank: assert property ($countones(~bank_select_n) <= 1)
    else $error("more than one bank selected");
  chk_protect_quiet: assert property (!protect_hold_n |-> &bank_select_n && we_n && oe_n && !req_ready)
    else $error("pins active while protected");
  chk_write_drive: assert property (!we_n |-> !data_oe && oe_n && !(&bank_select_n))
    else $error("bad write strobe levels");
  chk_read_float: assert property (!oe_n |-> data_oe && we_n)
    else $error("bus driven during read");
  chk_load_spacing: assert property ($fell(we_n) |-> gap_ff >= 39)
    else $error("byte loads too close");
  chk_protect_setup: assert property ($fell(we_n) |-> hold_ff >= PROTECT_WAIT - 1)
    else $error("write too soon after protect release");
  chk_read_answer: assert property (req_valid && req_ready && !req_write |-> ##12 rsp_valid)
    else $error("read answer late");
  chk_write_start: assert property ($rose(we_n) |-> (&bank_select_n) [*6])
    else $error("access inside write start time");
  chk_page_limit: assert property (page_error |-> we_n)
    else $error("load after full page");

  cover property (rsp_valid);
  cover property ($fell(we_n));
  cover property ($rose(page_error));
endmodule
